// ==== pkg/ormp_consts.vh ====
`ifndef ORMP_CONSTS_VH
`define ORMP_CONSTS_VH
`define ORMP_OP_OR        6'h04
`define ORMP_OP_COPY      6'h14
`define ORMP_OP_PTR1      8'hee
`define ORMP_OP_PTR2      8'hf0
`define ORMP_PTR1_ZERO    2'h0
`define ORMP_BIT_D        9
`define ORMP_BIT_A        8
`define ORMP_IDX_MAX      8'h5f
`define ORMP_ACC_BANK     4'h0
`define ORMP_ACC_HI_BANK  4'hf
`define ORMP_ACC_SPLIT    8'h60
`define ORMP_ACC_RST      8'h00
`define ORMP_PTR_RST      12'h000
`define ORMP_NUM_PTR      3
`endif

// ==== core/ormp_decode.v ====
`timescale 1ns/1ps
`include "ormp_consts.vh"
// Overview of operation
// RULE1: or opcode ors accumulator with file, sets n,z
// RULE2: destination bit picks accumulator or file
// RULE3: access bit picks access bank or bank select
// RULE4: extended set, a=0, f<=95 means indexed offset
// RULE5: copy opcode moves file to destination, sets n,z
// RULE6: copy source anywhere in selected 256-byte bank
// RULE7: pointer load puts 12-bit literal in pointer
// RULE8: or/copy one cycle; pointer load two words
module ormp_decode (
    input  wire        ref_clk_in,
    input  wire        rstn_in,
    input  wire        instr_valid_in,
    input  wire [15:0] instr_word_in,
    input  wire        ext_set_en_in,
    input  wire [3:0]  bank_select_register_in,
    input  wire [7:0]  file_rdata_in,
    output wire [11:0] file_addr_out,
    output reg  [7:0]  file_wdata_out,
    output reg         file_we_out,
    output reg         file_waddr_valid_out,
    output reg  [11:0] file_waddr_out,
    output reg  [7:0]  accumulator_out,
    output reg         flag_n_out,
    output reg         flag_z_out,
    output reg         busy_out,
    output reg  [11:0] pointer0_out,
    output reg  [11:0] pointer1_out,
    output reg  [11:0] pointer2_out
);
    localparam ST_IDLE = 2'b01;
    localparam ST_LOW  = 2'b10;

    reg  [1:0]  state_reg;
    reg  [1:0]  ptr_sel_reg;
    reg  [7:0]  result;
    reg  [11:0] addr;
    wire [7:0]  f_field = instr_word_in[7:0];
    wire        d_bit   = instr_word_in[`ORMP_BIT_D];
    wire        a_bit   = instr_word_in[`ORMP_BIT_A];
    wire        is_or   = instr_word_in[15:10] == `ORMP_OP_OR;
    wire        is_copy = instr_word_in[15:10] == `ORMP_OP_COPY;
    wire        is_ptr1 = (instr_word_in[15:8] == `ORMP_OP_PTR1) &&
                          (instr_word_in[7:6] == `ORMP_PTR1_ZERO) &&
                          (instr_word_in[5:4] != 2'h3);
    wire        is_ptr2 = instr_word_in[15:8] == `ORMP_OP_PTR2;
    wire        idle    = state_reg == ST_IDLE;
    wire        do_byte = instr_valid_in && idle && (is_or || is_copy);

    // RULE4: indexed offset select
    wire        indexed = !a_bit && ext_set_en_in && (f_field <= `ORMP_IDX_MAX);

    always @* begin
        // RULE3: access bank or bank select
        // RULE6: full 256-byte bank reach
        if (indexed) begin
            addr = pointer2_out + {4'h0, f_field};
        end else if (a_bit) begin
            addr = {bank_select_register_in, f_field};
        end else if (f_field < `ORMP_ACC_SPLIT) begin
            addr = {`ORMP_ACC_BANK, f_field};
        end else begin
            addr = {`ORMP_ACC_HI_BANK, f_field};
        end
        // RULE1: inclusive or
        if (is_or) begin
            result = accumulator_out | file_rdata_in;
        end else begin
            // RULE5: plain copy
            result = file_rdata_in;
        end
    end

    assign file_addr_out = addr;

    always @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg            <= ST_IDLE;
            ptr_sel_reg          <= 2'h0;
            file_wdata_out       <= 8'h00;
            file_we_out          <= 1'b0;
            file_waddr_valid_out <= 1'b0;
            file_waddr_out       <= 12'h000;
            accumulator_out      <= `ORMP_ACC_RST;
            flag_n_out           <= 1'b0;
            flag_z_out           <= 1'b0;
            busy_out             <= 1'b0;
            pointer0_out         <= `ORMP_PTR_RST;
            pointer1_out         <= `ORMP_PTR_RST;
            pointer2_out         <= `ORMP_PTR_RST;
        end else begin
            file_we_out          <= 1'b0;
            file_waddr_valid_out <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (do_byte) begin
                        // RULE8: single-cycle byte op
                        flag_n_out <= result[7];
                        flag_z_out <= result == 8'h00;
                        // RULE2: destination steer
                        if (d_bit) begin
                            file_we_out          <= 1'b1;
                            file_waddr_valid_out <= 1'b1;
                            file_waddr_out       <= addr;
                            file_wdata_out       <= result;
                        end else begin
                            accumulator_out <= result;
                        end
                    end else if (instr_valid_in && is_ptr1) begin
                        // RULE7: high nibble first
                        ptr_sel_reg <= instr_word_in[5:4];
                        case (instr_word_in[5:4])
                            2'h0: pointer0_out[11:8] <= instr_word_in[3:0];
                            2'h1: pointer1_out[11:8] <= instr_word_in[3:0];
                            default: pointer2_out[11:8] <= instr_word_in[3:0];
                        endcase
                        busy_out  <= 1'b1;
                        state_reg <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (instr_valid_in) begin
                        // RULE8: second word low byte
                        if (is_ptr2) begin
                            // RULE7: low byte load
                            case (ptr_sel_reg)
                                2'h0: pointer0_out[7:0] <= instr_word_in[7:0];
                                2'h1: pointer1_out[7:0] <= instr_word_in[7:0];
                                default: pointer2_out[7:0] <= instr_word_in[7:0];
                            endcase
                        end
                        busy_out  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                    busy_out  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // ormp_decode

// ==== dv/ormp_decode_sva.sv ====
`timescale 1ns/1ps
module ormp_chk (
    input logic        ref_clk_in, rstn_in, instr_valid_in, ext_set_en_in, busy_out,
    input logic        file_we_out, flag_n_out, flag_z_out,
    input logic [15:0] instr_word_in,
    input logic [3:0]  bank_select_register_in,
    input logic [7:0]  file_rdata_in, file_wdata_out, accumulator_out,
    input logic [11:0] file_addr_out, pointer0_out, pointer2_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    logic [7:0] or_reg;
    wire [15:0] w = instr_word_in;
    wire v = instr_valid_in && !busy_out;
    wire bo = v && (w[15:10] == 6'h04 || w[15:10] == 6'h14);
    wire ix = bo && !w[8] && ext_set_en_in && w[7:0] <= 8'h5f;
    always @(posedge ref_clk_in) or_reg <= accumulator_out | file_rdata_in;
    a_or_file: assert property (v && w[15:9] == 7'h09 |=>
        file_we_out && file_wdata_out == or_reg) else $error("or write");
    a_copy_acc: assert property (v && w[15:9] == 7'h28 |=>
        accumulator_out == $past(file_rdata_in)) else $error("copy acc");
    a_access_bank: assert property (bo && !w[8] && !ix |->
        file_addr_out == {(w[7:0] < 8'h60) ? 4'h0 : 4'hf, w[7:0]}) else $error("access");
    a_bank_select: assert property (bo && w[8] |->
        file_addr_out == {bank_select_register_in, w[7:0]}) else $error("bank");
    a_indexed_offset: assert property (ix |->
        file_addr_out == pointer2_out + w[7:0]) else $error("indexed");
    a_ptr_high: assert property (v && w[15:4] == 12'hee0 |=>
        busy_out && pointer0_out[11:8] == $past(w[3:0])) else $error("ptr high");
    a_busy_once: assert property (busy_out |=> !busy_out) else $error("busy");
    a_flags_result: assert property (file_we_out |->
        flag_z_out == (file_wdata_out == 8'h00) && flag_n_out == file_wdata_out[7]) else $error("flags");
    cover property (ix);
    cover property (busy_out);
    cover property (file_we_out);
endmodule // ormp_chk

// ==== dv/tb_ormp_decode.sv ====
`timescale 1ns/1ps
module tb_ormp_decode;
    logic        ref_clk_in = 0, rstn_in = 0, instr_valid_in = 0, ext_set_en_in = 0;
    logic [15:0] instr_word_in = 0;
    logic [3:0]  bank_select_register_in = 0;
    logic [7:0]  file_rdata_in = 0, file_wdata_out, accumulator_out, acc = 0, r, res;
    logic [11:0] file_addr_out, file_waddr_out, pointer0_out, pointer1_out, pointer2_out, a;
    logic        file_we_out, file_waddr_valid_out, flag_n_out, flag_z_out, busy_out;
    logic [35:0] p;
    logic [19:0] q[$];
    logic [31:0] rs = 76808;
    int          fails = 0, comparisons = 0, cyc = 0;
    ormp_decode dut (.*);
    always #50 ref_clk_in = ~ref_clk_in;
    function logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [35:0] s, e, input string n);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task report_and_stop;
        if (fails == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task drive(input logic [15:0] w);
        @(posedge ref_clk_in);
        instr_valid_in <= 1;
        instr_word_in <= w;
    endtask
    always @(negedge ref_clk_in) begin
        if (++cyc > 2000) begin
            fails++;
            report_and_stop;
        end
        if (file_we_out) chk({file_waddr_out, file_wdata_out}, q.pop_front(), "write");
        chk(file_waddr_valid_out, file_we_out, "waddr valid");
    end
    initial begin
        repeat (12) @(posedge ref_clk_in);
        rstn_in <= 1;
        for (int s = 0; s < 3; s++) begin
            rs = nx(rs);
            a = (s == 2) ? 12'h3ab : rs[11:0];
            p[s*12 +: 12] = a;
            drive({8'hee, 2'h0, s[1:0], a[11:8]});
            drive({8'hf0, a[7:0]});
        end
        for (int i = 0; i < 60; i++) begin
            rs = nx(rs);
            r = rs[15:8];
            res = rs[4] ? (acc | r) : r;
            if (rs[3]) a = {rs[19:16], rs[7:0]};
            else if (rs[20] && rs[7:0] <= 8'h5f) a = p[35:24] + rs[7:0];
            else a = {(rs[7:0] < 8'h60) ? 4'h0 : 4'hf, rs[7:0]};
            drive({(rs[4] ? 6'h04 : 6'h14), rs[5], rs[3], rs[7:0]});
            ext_set_en_in <= rs[20];
            bank_select_register_in <= rs[19:16];
            file_rdata_in <= r;
            if (rs[5]) q.push_back({a, res});
            else acc = res;
        end
        @(posedge ref_clk_in);
        instr_valid_in <= 0;
        repeat (2) @(negedge ref_clk_in);
        chk({pointer2_out, pointer1_out, pointer0_out}, p, "pointers");
        chk(accumulator_out, acc, "acc");
        chk({flag_z_out, flag_n_out}, {res == 8'h00, res[7]}, "flags");
        chk(36'(q.size()), 0, "writes left");
        report_and_stop;
    end
endmodule // tb_ormp_decode
bind ormp_decode ormp_chk u_chk (.*);
